// ### hdl/tepc_regs.vh
// Register offsets, fields, reset values and taps of the event and pulse counter
`ifndef TEPC_REGS_VH
`define TEPC_REGS_VH

// ==========================================================
// Register offsets
`define TEPC_ADDR_CTRL1   8'h00
`define TEPC_ADDR_CTRL2   8'h04
`define TEPC_ADDR_CMP     8'h08
`define TEPC_ADDR_STATUS  8'h0c
`define TEPC_ADDR_SYS     8'h10

// ==========================================================
// Control 1 fields
`define TEPC_C1_RUN       1:0
`define TEPC_C1_MODE      3:2
`define TEPC_C1_SRC       6:4
`define TEPC_C1_CLR       7

// ==========================================================
// Control 2, system and status fields
`define TEPC_C2_EDGE      0
`define TEPC_C2_GEDG      1
`define TEPC_SYS_DV       0
`define TEPC_SYS_SLOW     1
`define TEPC_ST_OVF       0
`define TEPC_ST_PIN       1
`define TEPC_ST_RUN       2

// ==========================================================
// Values and reset values
`define TEPC_RUN_STOP     2'h0
`define TEPC_MODE_TIMER   2'h0
`define TEPC_MODE_EVENT   2'h1
`define TEPC_MODE_PULSE   2'h2
`define TEPC_CNT_W        18
`define TEPC_CNT_MAX      18'h3ffff
`define TEPC_CNT_ZERO     18'h00000
`define TEPC_CMP_RST      18'h00001
`define TEPC_LOW_MASK     18'h007ff
`define TEPC_RST_C1       8'h00
`define TEPC_RST_C2       2'h0
`define TEPC_RST_SYS      2'h0

// ==========================================================
// Source clock selections and divider taps
`define TEPC_SRC_T0       3'h0
`define TEPC_SRC_T1       3'h1
`define TEPC_SRC_T2       3'h2
`define TEPC_SRC_T3       3'h3
`define TEPC_SRC_T4       3'h4
`define TEPC_SRC_FC       3'h5
`define TEPC_SRC_FS       3'h6
`define TEPC_SRC_EXT      3'h7
`define TEPC_HC_T0        23
`define TEPC_HC_T1        13
`define TEPC_HC_T2        11
`define TEPC_HC_T3        7
`define TEPC_HC_T4        3
`define TEPC_LS_T0        15
`define TEPC_LS_T1        5
`define TEPC_LS_T2        3
`define TEPC_FS_DIV       1526
`define TEPC_HC_W         23
`define TEPC_LS_W         15

`endif

// ### hdl/tepc_prescaler.v
// Divider chain giving high and low clock tap enables
`timescale 1ns/1ps
`default_nettype none
`include "tepc_regs.vh"

module tepc_prescaler #(
  parameter HC_W   = `TEPC_HC_W,
  parameter LS_W   = `TEPC_LS_W,
  parameter FS_DIV = `TEPC_FS_DIV
) (
  input  wire            pclk,
  input  wire            presetn,
  output wire [HC_W:0]   hc_tick,
  output wire [LS_W:0]   ls_tick
);

  // ==========================================================
  // Counters
  reg  [HC_W-1:0] hc;
  reg  [LS_W-1:0] ls;
  reg  [31:0]     fdiv;
  wire            fs_tick;

  assign fs_tick = (fdiv == FS_DIV - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc   <= {HC_W{1'b0}};
      ls   <= {LS_W{1'b0}};
      fdiv <= 32'h00000000;
    end else begin
      hc <= hc + 1'b1;
      if (fs_tick) begin
        fdiv <= 32'h00000000;
        ls   <= ls + 1'b1;
      end else begin
        fdiv <= fdiv + 32'h00000001;
      end
    end
  end

  // ==========================================================
  // Tap enables: tap i pulses once per 2^i source periods
  genvar i;
  generate
    for (i = 0; i <= HC_W; i = i + 1) begin : g_hc
      wire [HC_W-1:0] m = {HC_W{1'b1}} >> (HC_W - i);
      assign hc_tick[i] = &(hc | ~m);
    end
    for (i = 0; i <= LS_W; i = i + 1) begin : g_ls
      wire [LS_W-1:0] m = {LS_W{1'b1}} >> (LS_W - i);
      assign ls_tick[i] = fs_tick & (&(ls | ~m));
    end
  endgenerate

endmodule // tepc_prescaler
`default_nettype wire

// ### hdl/tepc_counter.v
// Timer, event counter and pulse width counter with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "tepc_regs.vh"

// Functional notes
// - Timer mode counts one per selected prescaler tick.
// - Timer mode: counter equal to compare raises irq and clears counter.
// - After that clear, counting carries on from zero by itself.
// - Undivided fast clock in slow mode compares upper 7 bits only.
// - Event mode counts once per falling edge of the event pin.
// - Event mode: equality raises irq, clears count, counting then resumes.
// - Pulse mode counts internal ticks while the event pin is high.
// - Pulse mode irq on pin falling edge, or both edges if selected.
// - Without a clear, pulse counting resumes from the held value.
// - Wrap from all ones to zero sets the overflow flag.
// - Overflow flag holds until the counter clear is issued.
// - Pulse mode: stopping while pin high raises the irq.
// - Reading the compare location returns the live counter.
module tepc_counter #(
  parameter FS_DIV = `TEPC_FS_DIV
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        event_input_pin,
  output reg         counter_match_irq,
  output reg         overflow_flag
);

  // ==========================================================
  // Address decode
  function is_mapped;
    input [7:0] a;
    begin
      if (a == `TEPC_ADDR_CTRL1) begin
        is_mapped = 1'b1;
      end else if (a == `TEPC_ADDR_CTRL2) begin
        is_mapped = 1'b1;
      end else if (a == `TEPC_ADDR_CMP) begin
        is_mapped = 1'b1;
      end else if (a == `TEPC_ADDR_STATUS) begin
        is_mapped = 1'b1;
      end else if (a == `TEPC_ADDR_SYS) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = 1'b0;
      end
    end
  endfunction

  // ==========================================================
  // Declarations
  reg  [1:0]                run_control;
  reg  [1:0]                mode;
  reg  [2:0]                source_clock_select;
  reg                       input_edge_select;
  reg                       gate_irq_edge_select;
  reg                       divider_tap_select;
  reg                       slow_mode;
  reg  [`TEPC_CNT_W-1:0]    compare_value;
  reg  [`TEPC_CNT_W-1:0]    count;
  reg                       pin_meta;
  reg                       pin_sync;
  reg                       pin_last;
  reg                       tick;
  reg                       next_pready;
  reg  [31:0]               next_prdata;
  reg  [`TEPC_CNT_W-1:0]    next_count;
  reg                       next_overflow;
  reg                       next_irq;
  reg                       wr_ctrl1;
  reg                       wr_ctrl2;
  reg                       wr_cmp;
  reg                       wr_sys;
  wire [`TEPC_HC_W:0]       hc_tick;
  wire [`TEPC_LS_W:0]       ls_tick;
  wire                      wr_done;
  wire                      running;
  wire                      pin_fall;
  wire                      pin_rise;
  wire                      low_src;
  wire                      inc;
  wire                      masked_cmp;
  wire                      match;
  wire                      clr_req;
  wire                      stop_high;
  wire                      gate_irq;
  wire [`TEPC_CNT_W-1:0]    count_inc;

  // ==========================================================
  // Prescaler
  tepc_prescaler #(
    .HC_W   (`TEPC_HC_W),
    .LS_W   (`TEPC_LS_W),
    .FS_DIV (FS_DIV)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .hc_tick (hc_tick),
    .ls_tick (ls_tick)
  );

  // ==========================================================
  // Source clock selection
  assign low_src = divider_tap_select | slow_mode;

  always @* begin
    case (source_clock_select)
      `TEPC_SRC_T0: begin
        tick = low_src ? ls_tick[`TEPC_LS_T0] : hc_tick[`TEPC_HC_T0];
      end
      `TEPC_SRC_T1: begin
        tick = low_src ? ls_tick[`TEPC_LS_T1] : hc_tick[`TEPC_HC_T1];
      end
      `TEPC_SRC_T2: begin
        tick = low_src ? ls_tick[`TEPC_LS_T2] : hc_tick[`TEPC_HC_T2];
      end
      `TEPC_SRC_T3: begin
        tick = ~slow_mode & hc_tick[`TEPC_HC_T3];
      end
      `TEPC_SRC_T4: begin
        tick = ~slow_mode & hc_tick[`TEPC_HC_T4];
      end
      `TEPC_SRC_FC: begin
        tick = hc_tick[0];
      end
      `TEPC_SRC_FS: begin
        tick = ls_tick[0];
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Event pin synchroniser and edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= event_input_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign pin_fall = pin_last & ~pin_sync;
  assign pin_rise = ~pin_last & pin_sync;

  // ==========================================================
  // Write strobes, one per writable register (none for status), only at the completing edge
  always @* begin
    wr_ctrl1 = 1'b0;
    wr_ctrl2 = 1'b0;
    wr_cmp   = 1'b0;
    wr_sys   = 1'b0;
    if (paddr == `TEPC_ADDR_CTRL1) begin
      wr_ctrl1 = wr_done;
    end else if (paddr == `TEPC_ADDR_CTRL2) begin
      wr_ctrl2 = wr_done;
    end else if (paddr == `TEPC_ADDR_CMP) begin
      wr_cmp = wr_done;
    end else if (paddr == `TEPC_ADDR_SYS) begin
      wr_sys = wr_done;
    end
  end

  // ==========================================================
  // Counting, compare and overflow
  assign wr_done   = psel & penable & pready & pwrite;
  assign running   = (run_control != `TEPC_RUN_STOP);
  assign count_inc = count + 1'b1;
  assign clr_req   = wr_ctrl1 & pwdata[`TEPC_C1_CLR];

  assign inc = running & (
      ((mode == `TEPC_MODE_TIMER) & tick) |
      ((mode == `TEPC_MODE_EVENT) & pin_fall) |
      ((mode == `TEPC_MODE_PULSE) & tick & pin_sync));

  // Slow mode on undivided fast clock ignores the low compare bits
  assign masked_cmp = slow_mode & (source_clock_select == `TEPC_SRC_FC);

  assign match = inc & (mode != `TEPC_MODE_PULSE) &
      (((count_inc ^ compare_value) & ~(masked_cmp ? `TEPC_LOW_MASK : `TEPC_CNT_ZERO))
       == `TEPC_CNT_ZERO);

  assign gate_irq = running & (mode == `TEPC_MODE_PULSE) &
      (pin_fall | (gate_irq_edge_select & pin_rise));

  assign stop_high = wr_ctrl1 &
      (pwdata[`TEPC_C1_RUN] == `TEPC_RUN_STOP) &
      (mode == `TEPC_MODE_PULSE) & pin_sync;

  // ==========================================================
  // Next count: clear beats match, match beats increment
  always @* begin
    next_count = count;
    if (clr_req) begin
      next_count = `TEPC_CNT_ZERO;
    end else if (match) begin
      next_count = `TEPC_CNT_ZERO;
    end else if (inc) begin
      next_count = count_inc;
    end
  end

  // ==========================================================
  // Next overflow: a wrap in the same cycle as a clear wins
  always @* begin
    next_overflow = overflow_flag;
    if (inc & (count == `TEPC_CNT_MAX)) begin
      next_overflow = 1'b1;
    end else if (clr_req) begin
      next_overflow = 1'b0;
    end
  end

  // ==========================================================
  // Next interrupt: one-cycle pulse from match, gate edge or stop
  always @* begin
    next_irq = 1'b0;
    if (match) begin
      next_irq = 1'b1;
    end else if (gate_irq) begin
      next_irq = 1'b1;
    end else if (stop_high) begin
      next_irq = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count             <= `TEPC_CNT_ZERO;
      overflow_flag     <= 1'b0;
      counter_match_irq <= 1'b0;
    end else begin
      count             <= next_count;
      overflow_flag     <= next_overflow;
      counter_match_irq <= next_irq;
    end
  end

  // ==========================================================
  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_control         <= `TEPC_RUN_STOP;
      mode                <= `TEPC_MODE_TIMER;
      source_clock_select <= `TEPC_SRC_T0;
    end else if (wr_ctrl1) begin
      run_control         <= pwdata[`TEPC_C1_RUN];
      mode                <= pwdata[`TEPC_C1_MODE];
      source_clock_select <= pwdata[`TEPC_C1_SRC];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_edge_select    <= 1'b0;
      gate_irq_edge_select <= 1'b0;
    end else if (wr_ctrl2) begin
      input_edge_select    <= pwdata[`TEPC_C2_EDGE];
      gate_irq_edge_select <= pwdata[`TEPC_C2_GEDG];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value <= `TEPC_CMP_RST;
    end else if (wr_cmp) begin
      compare_value <= pwdata[`TEPC_CNT_W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_tap_select <= 1'b0;
      slow_mode          <= 1'b0;
    end else if (wr_sys) begin
      divider_tap_select <= pwdata[`TEPC_SYS_DV];
      slow_mode          <= pwdata[`TEPC_SYS_SLOW];
    end
  end

  // ==========================================================
  // Read data
  always @* begin
    next_prdata = 32'h00000000;
    if (paddr == `TEPC_ADDR_CTRL1) begin
      next_prdata[`TEPC_C1_RUN]  = run_control;
      next_prdata[`TEPC_C1_MODE] = mode;
      next_prdata[`TEPC_C1_SRC]  = source_clock_select;
    end else if (paddr == `TEPC_ADDR_CTRL2) begin
      next_prdata[`TEPC_C2_EDGE] = input_edge_select;
      next_prdata[`TEPC_C2_GEDG] = gate_irq_edge_select;
    end else if (paddr == `TEPC_ADDR_CMP) begin
      next_prdata[`TEPC_CNT_W-1:0] = count;
    end else if (paddr == `TEPC_ADDR_STATUS) begin
      next_prdata[`TEPC_ST_OVF] = overflow_flag;
      next_prdata[`TEPC_ST_PIN] = pin_sync;
      next_prdata[`TEPC_ST_RUN] = running;
    end else if (paddr == `TEPC_ADDR_SYS) begin
      next_prdata[`TEPC_SYS_DV]   = divider_tap_select;
      next_prdata[`TEPC_SYS_SLOW] = slow_mode;
    end
  end

  // ==========================================================
  // APB handshake: one wait state per access
  always @* begin
    next_pready = psel & penable & ~pready;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= next_pready;
      if (next_pready) begin
        pslverr <= ~is_mapped(paddr);
        prdata  <= pwrite ? 32'h00000000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
      end
    end
  end

endmodule // tepc_counter
`default_nettype wire

// ### tb/tepc_event_src.sv
// External pulse source model driving the event pin
`timescale 1ns/1ps
`default_nettype none

module tepc_event_src (
  input  wire logic pclk,
  output var  logic event_input_pin
);
  // ==========================================
  // Pulse generation
  initial event_input_pin = 1'b0;

  // Callers keep phases at least 2 cycles and periods at least 16
  task automatic pulse(input int hi, input int lo);
    @(posedge pclk);
    event_input_pin <= 1'b1;
    repeat (hi) @(posedge pclk);
    event_input_pin <= 1'b0;
    repeat (lo) @(posedge pclk);
  endtask

  task automatic set(input logic v);
    @(posedge pclk);
    event_input_pin <= v;
  endtask
endmodule // tepc_event_src

`default_nettype wire

// ### tb/tepc_counter_chk.sv
// Assertions on the counter block ports
`timescale 1ns/1ps
`default_nettype none
`include "tepc_regs.vh"

module tepc_counter_chk #(
  parameter FS_DIV = `TEPC_FS_DIV
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        event_input_pin,
  input wire logic        counter_match_irq,
  input wire logic        overflow_flag
);
  // ==========================================
  // Helper state
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] mode_run;
  wire        wr1 = psel && penable && pready && pwrite && paddr == `TEPC_ADDR_CTRL1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_run <= 4'h0;
    else if (wr1) mode_run <= pwdata[3:0];
  end
  sequence s_pin_high;
    event_input_pin [*4];
  endsequence
  sequence s_stop_pulse;
    wr1 && pwdata[3:0] == 4'h8 && mode_run[3:2] == `TEPC_MODE_PULSE && mode_run[1:0] != 2'h0;
  endsequence

  // ==========================================
  // Properties
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_access: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not in second access cycle");
  a_ready_idle: assert property (!(psel && penable) |=> !pready) else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero outside answer");
  a_unmapped_err: assert property (psel && penable && !$past(penable) && paddr > 8'h10 |=> pslverr)
    else $error("unmapped access without error");
  a_ovf_sticky: assert property (overflow_flag && !(wr1 && pwdata[7]) |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  a_stop_high_irq: assert property (s_pin_high ##0 s_stop_pulse |-> ##[1:3] counter_match_irq)
    else $error("no irq on stop with pin high");
  a_pulse_fall_irq: assert property (mode_run == 4'h9 && $fell(event_input_pin) |-> ##[2:6] counter_match_irq)
    else $error("no irq on pin falling edge");
endmodule // tepc_counter_chk

bind tepc_counter tepc_counter_chk #(.FS_DIV(FS_DIV)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .event_input_pin(event_input_pin), .counter_match_irq(counter_match_irq),
  .overflow_flag(overflow_flag));

`default_nettype wire

// ### tb/tepc_counter_tb.sv
// Self-checking testbench for the counter block
`timescale 1ns/1ps
`default_nettype none
`include "tepc_regs.vh"

module tepc_counter_tb;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin, irq, ovf;
  int          fail_count, comparisons, irqs, n0;

  tepc_counter #(.FS_DIV(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_input_pin(pin), .counter_match_irq(irq), .overflow_flag(ovf));
  tepc_event_src u_src (.pclk(pclk), .event_input_pin(pin));

  // ==========================================
  // Clock, irq counter and tasks
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(negedge pclk) if (irq === 1'b1) irqs++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    wrap_up;
  end

  // ==========================================
  // Tests
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0; presetn = 1'b0;
    irqs = 0; fail_count = 0; comparisons = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`TEPC_ADDR_CTRL1, 32'h0, "ctrl1 reset");
    rdc(`TEPC_ADDR_CTRL2, 32'h0, "ctrl2 reset");
    rdc(`TEPC_ADDR_CMP, 32'h0, "count reset");
    rdc(`TEPC_ADDR_STATUS, 32'h0, "status reset");
    rdc(`TEPC_ADDR_SYS, 32'h0, "sys reset");
    rdc(8'h20, 32'h0, "unmapped data");
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("reset test done");
    apb(1'b1, `TEPC_ADDR_CMP, 32'h5);
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h51);
    n0 = irqs;
    repeat (50) @(posedge pclk);
    chk(irqs - n0, 32'h9, "timer matches");
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h0);
    apb(1'b0, `TEPC_ADDR_CMP, 32'h0);
    chk({31'h0, rd < 32'h5}, 32'h1, "live count below compare");
    apb(1'b1, `TEPC_ADDR_SYS, 32'h2);
    apb(1'b1, `TEPC_ADDR_CMP, 32'hfff);
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h51);
    n0 = irqs;
    repeat (4096) @(posedge pclk);
    chk(irqs - n0, 32'h2, "slow mode masked matches");
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h80);
    apb(1'b1, `TEPC_ADDR_SYS, 32'h0);
    apb(1'b1, `TEPC_ADDR_CMP, 32'h2);
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h41);
    n0 = irqs;
    repeat (161) @(posedge pclk);
    chk(irqs - n0, 32'ha, "fast tap matches");
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h80);
    apb(1'b1, `TEPC_ADDR_SYS, 32'h1);
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h21);
    n0 = irqs;
    repeat (161) @(posedge pclk);
    chk(irqs - n0, 32'h2, "divided slow tap matches");
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h80);
    apb(1'b1, `TEPC_ADDR_SYS, 32'h0);
    $display("timer test done");
    apb(1'b1, `TEPC_ADDR_CTRL2, 32'h0);
    apb(1'b1, `TEPC_ADDR_CMP, 32'h3);
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h75);
    n0 = irqs;
    repeat (7) u_src.pulse(8, 8);
    chk(irqs - n0, 32'h2, "event matches");
    rdc(`TEPC_ADDR_CMP, 32'h1, "event count");
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h80);
    $display("event test done");
    apb(1'b1, `TEPC_ADDR_CMP, 32'h3ffff);
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h59);
    n0 = irqs;
    u_src.pulse(20, 16);
    chk(irqs - n0, 32'h1, "pulse fall irq");
    rdc(`TEPC_ADDR_CMP, 32'h14, "pulse width");
    u_src.pulse(10, 16);
    rdc(`TEPC_ADDR_CMP, 32'h1e, "pulse resume");
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h58);
    apb(1'b1, `TEPC_ADDR_CTRL2, 32'h2);
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'hd9);
    n0 = irqs;
    u_src.pulse(10, 16);
    chk(irqs - n0, 32'h2, "both edge irq");
    rdc(`TEPC_ADDR_CMP, 32'ha, "cleared then counted");
    u_src.set(1'b1);
    repeat (8) @(posedge pclk);
    n0 = irqs;
    apb(1'b1, `TEPC_ADDR_CTRL1, 32'h58);
    repeat (4) @(posedge pclk);
    chk(irqs - n0, 32'h1, "stop while high irq");
    rdc(`TEPC_ADDR_STATUS, 32'h2, "no overflow, pin high");
    chk({31'h0, ovf}, 32'h0, "overflow output clear");
    u_src.set(1'b0);
    $display("pulse test done");
    wrap_up;
  end
endmodule // tepc_counter_tb

`default_nettype wire
